// >>> dv/ocs_osc_ctrl_test.sv
// Self-checking bench for the oscillator select and trim block.
// Assumes the package and design files under logic/ are compiled first.
`timescale 1ns/100ps

module ocs_osc_ctrl_test;
   import ocs_pkg::*;

   // ---------------------------------------------------------------
   // Signals
   // ---------------------------------------------------------------
   logic         mclk;
   logic         sys_rst;
   ocs_bus_req_t busReq;
   logic [7:0]   regRdData;
   ocs_nv_trim_t nvTrim;
   logic         stopRecovery;
   logic         lowPowerOptionN;
   logic         flashReadActive;
   logic         xtalSlowPin;
   logic [7:0]   oscCtrl;
   ocs_src_t     sysclkSourceSelect;
   logic [9:0]   freqTrim;
   logic [5:0]   tempTrim;
   logic         sysClkTick;
   logic         flashPowerDown;
   int           fails = 0;
   int           n_compared = 0;
   int           cycles = 0;
   int           nTick;
   int           nDown;

   // Free-running 100 MHz clock
   initial mclk = 1'b0;
   always #5 mclk = ~mclk;

   ocs_osc_ctrl dut_u (
      .mclk               (mclk),
      .sys_rst            (sys_rst),
      .busReq             (busReq),
      .regRdData          (regRdData),
      .nvTrim             (nvTrim),
      .stopRecovery       (stopRecovery),
      .lowPowerOptionN    (lowPowerOptionN),
      .flashReadActive    (flashReadActive),
      .xtalSlowPin        (xtalSlowPin),
      .oscCtrl            (oscCtrl),
      .sysclkSourceSelect (sysclkSourceSelect),
      .freqTrim           (freqTrim),
      .tempTrim           (tempTrim),
      .sysClkTick         (sysClkTick),
      .flashPowerDown     (flashPowerDown)
   );

   // ---------------------------------------------------------------
   // Helper tasks
   // ---------------------------------------------------------------
   // Compare and count; four-state compare so an unknown bit matches only an unknown bit
   task automatic check(input logic [15:0] got, input logic [15:0] exp);
      n_compared++;
      if (got !== exp) begin
         fails++;
         $display("ERROR at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   // One write strobe, driven off the falling edge
   task automatic wr_reg(input logic [11:0] addr, input logic [7:0] data);
      @(negedge mclk);
      busReq.addr  = addr;
      busReq.wdata = data;
      busReq.wr    = 1'b1;
      @(negedge mclk);
      busReq.wr    = 1'b0;
   endtask

   // Read data is registered, so it is looked at one cycle after the strobe
   task automatic rd_reg(input logic [11:0] addr, input logic [7:0] exp);
      @(negedge mclk);
      busReq.addr = addr;
      busReq.rd   = 1'b1;
      @(negedge mclk);
      busReq.rd   = 1'b0;
      check({8'h00, regRdData}, {8'h00, exp});
   endtask

   // Both keys in order at the control address
   task automatic unlock;
      wr_reg(OCS_ADDR_OSC_CTRL, OCS_KEY_FIRST);
      wr_reg(OCS_ADDR_OSC_CTRL, OCS_KEY_SECOND);
   endtask

   // Tick and power-down counts over a window; 40 is a multiple of every divide used
   task automatic count_window;
      nTick = 0;
      nDown = 0;
      repeat (40) begin
         @(negedge mclk);
         nTick += int'(sysClkTick);
         nDown += int'(flashPowerDown);
      end
   endtask

   // Single exit point for both normal end and hang
   task automatic final_report;
      $display("Comparisons %0d, mismatches %0d", n_compared, fails);
      if (fails == 0 && n_compared > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask

   // Hang guard; the sequence needs well under 2000 cycles
   always @(posedge mclk) begin
      cycles <= cycles + 1;
      if (cycles == 4000) begin
         fails++;
         final_report;
      end
   end

   // ---------------------------------------------------------------
   // Main sequence
   // ---------------------------------------------------------------
   initial begin
      sys_rst         = 1'b1;
      busReq          = '0;
      nvTrim.upper    = 8'hb6;
      nvTrim.lower    = 8'h3c;
      stopRecovery    = 1'b0;
      lowPowerOptionN = 1'b0;
      flashReadActive = 1'b0;
      xtalSlowPin     = 1'b0;
      repeat (2) @(negedge mclk);
      sys_rst = 1'b0;
      repeat (3) @(negedge mclk);

      // Reset state: precision source, low-power defaults, trims from storage
      check({8'h00, oscCtrl}, 16'h00a4);
      check({14'h0000, sysclkSourceSelect}, {14'h0000, OCS_SRC_PRECISION});
      check({6'h00, freqTrim}, {6'h00, nvTrim.upper[1:0], nvTrim.lower});
      check({10'h000, tempTrim}, {10'h000, nvTrim.upper[7:2]});
      rd_reg(OCS_ADDR_TRIM_INDEX, OCS_INDEX_RESET);
      rd_reg(OCS_ADDR_TRIM_VALUE, 8'h00);

      // Divide by 8 after reset, flash idles down on every tick
      count_window;
      check(16'(nTick), 16'h0005);
      check(16'(nDown), 16'h0005);
      flashReadActive = 1'b1;
      count_window;
      check(16'(nDown), 16'h0000);
      flashReadActive = 1'b0;

      // Index register holds full range; unimplemented slots read zero
      wr_reg(OCS_ADDR_TRIM_INDEX, OCS_TRIM_IDXMAX);
      rd_reg(OCS_ADDR_TRIM_INDEX, OCS_TRIM_IDXMAX);
      rd_reg(OCS_ADDR_TRIM_VALUE, 8'h00);
      wr_reg(OCS_ADDR_TRIM_INDEX, 8'h05);
      wr_reg(OCS_ADDR_TRIM_VALUE, 8'h77);
      rd_reg(OCS_ADDR_TRIM_VALUE, 8'h00);

      // Software trim writes act at once on the oscillator adjustment
      wr_reg(OCS_ADDR_TRIM_INDEX, OCS_TRIM_UPPER);
      rd_reg(OCS_ADDR_TRIM_VALUE, nvTrim.upper);
      wr_reg(OCS_ADDR_TRIM_VALUE, 8'h4b);
      check({10'h000, tempTrim}, 16'h0012);
      check({6'h00, freqTrim}, 16'h033c);
      rd_reg(OCS_ADDR_TRIM_VALUE, 8'h4b);
      wr_reg(OCS_ADDR_TRIM_INDEX, OCS_TRIM_LOWER);
      wr_reg(OCS_ADDR_TRIM_VALUE, 8'h95);
      check({6'h00, freqTrim}, 16'h0395);
      rd_reg(OCS_ADDR_TRIM_VALUE, 8'h95);

      // Stop recovery brings the stored image back
      @(negedge mclk);
      stopRecovery = 1'b1;
      @(negedge mclk);
      stopRecovery = 1'b0;
      repeat (2) @(negedge mclk);
      check({6'h00, freqTrim}, {6'h00, nvTrim.upper[1:0], nvTrim.lower});
      rd_reg(OCS_ADDR_TRIM_VALUE, nvTrim.lower);

      // Locked writes and wrong key order change nothing
      wr_reg(OCS_ADDR_OSC_CTRL, 8'h63);
      check({8'h00, oscCtrl}, 16'h00a4);
      wr_reg(OCS_ADDR_OSC_CTRL, OCS_KEY_SECOND);
      wr_reg(OCS_ADDR_OSC_CTRL, OCS_KEY_FIRST);
      wr_reg(OCS_ADDR_OSC_CTRL, 8'h63);
      check({8'h00, oscCtrl}, 16'h00a4);

      // Keys split by other traffic, then watchdog enabled and selected at once
      wr_reg(OCS_ADDR_OSC_CTRL, OCS_KEY_FIRST);
      rd_reg(OCS_ADDR_TRIM_INDEX, OCS_TRIM_LOWER);
      wr_reg(OCS_ADDR_TRIM_INDEX, OCS_TRIM_LOWER);
      wr_reg(OCS_ADDR_OSC_CTRL, OCS_KEY_SECOND);
      wr_reg(OCS_ADDR_OSC_CTRL, 8'h63);
      check({8'h00, oscCtrl}, 16'h0063);
      check({14'h0000, sysclkSourceSelect}, {14'h0000, OCS_SRC_WATCHDOG});
      wr_reg(OCS_ADDR_OSC_CTRL, 8'h20);
      check({8'h00, oscCtrl}, 16'h0063);

      // Divide register shares the key and relocks after one write
      unlock;
      wr_reg(OCS_ADDR_CLK_DIV, 8'h04);
      wr_reg(OCS_ADDR_OSC_CTRL, 8'h20);
      check({8'h00, oscCtrl}, 16'h0063);
      rd_reg(OCS_ADDR_CLK_DIV, 8'h04);
      count_window;
      check(16'(nTick), 16'h000a);
      wr_reg(OCS_ADDR_CLK_DIV, 8'h02);
      count_window;
      check(16'(nTick), 16'h000a);

      // Crystal: enable first, select with a second unlocked write
      unlock;
      wr_reg(OCS_ADDR_OSC_CTRL, 8'h67);
      check({14'h0000, sysclkSourceSelect}, {14'h0000, OCS_SRC_WATCHDOG});
      unlock;
      wr_reg(OCS_ADDR_OSC_CTRL, 8'h65);
      check({14'h0000, sysclkSourceSelect}, {14'h0000, OCS_SRC_CRYSTAL});

      // Fast crystal keeps flash powered; slow one lets it idle down
      count_window;
      check(16'(nDown), 16'h0000);
      xtalSlowPin = 1'b1;
      repeat (4) @(negedge mclk);
      count_window;
      check(16'(nDown), 16'h000a);

      // Reserved source code is not taken
      unlock;
      wr_reg(OCS_ADDR_OSC_CTRL, 8'h66);
      check({14'h0000, sysclkSourceSelect}, {14'h0000, OCS_SRC_CRYSTAL});

      // Mid-run reset with the low-power option off: plain defaults, undivided clock
      nvTrim.lower    = 8'h5a;
      lowPowerOptionN = 1'b1;
      sys_rst         = 1'b1;
      repeat (2) @(negedge mclk);
      sys_rst = 1'b0;
      repeat (3) @(negedge mclk);
      check({8'h00, oscCtrl}, {8'h00, OCS_CTRL_RESET});
      check({14'h0000, sysclkSourceSelect}, {14'h0000, OCS_SRC_PRECISION});
      check({6'h00, freqTrim}, {6'h00, nvTrim.upper[1:0], 8'h5a});
      count_window;
      check(16'(nTick), 16'h0028);
      check(16'(nDown), 16'h0000);

      final_report;
   end

endmodule // ocs_osc_ctrl_test

// >>> logic/ocs_clk_divider.sv
// Programmable divider producing a one-cycle system clock tick.
// Assumes divide value comes from a register on the same clock.
`timescale 1ns/100ps

module ocs_clk_divider #(
   parameter int WIDTH = 8
) (
   // Clock and reset
   input  wire logic             mclk,
   input  wire logic             sys_rst,
   // Divide value, 0 and 1 both mean no division
   input  wire logic [WIDTH-1:0] divValue,
   // Divided tick
   output logic                  clkTick
);
   import ocs_pkg::*;

   // Elaboration check: a one-bit counter cannot hold a divide value
   if (WIDTH < 2) begin : gen_width_check
      $error("ocs_clk_divider: WIDTH must be at least 2");
   end

   logic [WIDTH-1:0] countReg, countNext;
   logic             tickReg, tickNext;

   // ---------------------------------------------------------------
   // Counter: restarts on reaching divide-1, so a new value takes hold
   // no later than the end of the current period
   // ---------------------------------------------------------------
   always_comb begin
      countNext = countReg + {{(WIDTH-1){1'b0}}, 1'b1};
      tickNext  = 1'b0;
      if (divValue <= {{(WIDTH-1){1'b0}}, 1'b1} ||
          countReg >= divValue - {{(WIDTH-1){1'b0}}, 1'b1}) begin // RQ14
         countNext = '0;
         tickNext  = 1'b1;
      end
   end

   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         countReg <= '0;
         tickReg  <= 1'b0;
      end else begin
         countReg <= countNext;
         tickReg  <= tickNext;
      end
   end

   assign clkTick = tickReg;

   // ---------------------------------------------------------------
   // Checks
   // ---------------------------------------------------------------
   chk_div_period: assert property (@(posedge mclk) disable iff (sys_rst) // RQ14
      (clkTick && divValue == 8'h04 && $stable(divValue)) |->
      ##1 !clkTick ##1 !clkTick ##1 !clkTick ##1 (clkTick || divValue != 8'h04))
      else $error("divider period wrong for divide by four");
   chk_div_bypass: assert property (@(posedge mclk) disable iff (sys_rst) // RQ14
      (divValue <= 8'h01 && $past(divValue) <= 8'h01 && !$past(sys_rst)) |-> clkTick)
      else $error("undivided clock lost a tick");

endmodule // ocs_clk_divider

// >>> logic/ocs_osc_ctrl.sv
// Oscillator select, divider and trim access block, top level.
// Assumes a single-cycle register port on mclk, option and trim images
// driven from flash logic on the same clock.
`timescale 1ns/100ps

module ocs_osc_ctrl (
   // Clock and reset
   input  wire logic                 mclk,
   input  wire logic                 sys_rst,
   // Register port
   input  wire ocs_pkg::ocs_bus_req_t busReq,
   output logic [7:0]                regRdData,
   // Flash side inputs
   input  wire ocs_pkg::ocs_nv_trim_t nvTrim,
   input  wire logic                 stopRecovery,
   input  wire logic                 lowPowerOptionN,
   input  wire logic                 flashReadActive,
   // Crystal frequency strap from pin
   input  wire logic                 xtalSlowPin,
   // Oscillator controls
   output logic [7:0]                oscCtrl,
   output ocs_pkg::ocs_src_t         sysclkSourceSelect,
   output logic [9:0]                freqTrim,
   output logic [5:0]                tempTrim,
   output logic                      sysClkTick,
   output logic                      flashPowerDown
);
   import ocs_pkg::*;

   // ---------------------------------------------------------------
   // State
   // ---------------------------------------------------------------
   ocs_lock_t  lockReg, lockNext;
   logic [7:0] ctrlReg, ctrlNext;
   logic [7:0] divReg, divNext;
   logic [7:0] indexReg, indexNext;
   logic [7:0] trimUpReg, trimUpNext;
   logic [7:0] trimLoReg, trimLoNext;
   logic       reloadReg, reloadNext;
   logic       lpResetReg, lpResetNext;
   logic [7:0] rdReg, rdNext;
   logic       fpdReg, fpdNext;
   logic       xtalMeta, xtalSync;
   logic       tick;

   wire wrCtrl = busReq.wr && busReq.addr == OCS_ADDR_OSC_CTRL;
   wire wrDiv  = busReq.wr && busReq.addr == OCS_ADDR_CLK_DIV;
   wire wrTrim = busReq.wr && busReq.addr == OCS_ADDR_TRIM_VALUE;

   // Trim location lookup, unimplemented indexes read as zero
   function automatic logic [7:0] trimRead(input logic [7:0] idx,
                                           input logic [7:0] up,
                                           input logic [7:0] lo);
      logic [7:0] val;
      val = 8'h00;                                                  // RQ18
      if (idx == OCS_TRIM_UPPER) val = up;
      if (idx == OCS_TRIM_LOWER) val = lo;
      return val;
   endfunction

   // ---------------------------------------------------------------
   // Unlock tracker and locked registers
   // ---------------------------------------------------------------
   always_comb begin
      lockNext = lockReg;
      ctrlNext = ctrlReg;
      divNext  = divReg;
      // Only writes to the control address, or a divide write once unlocked, move the
      // tracker; other cycles in between leave it where it is
      unique case (lockReg)
         OCS_LOCKED: begin
            if (wrCtrl && busReq.wdata == OCS_KEY_FIRST) lockNext = OCS_GOT_KEY1; // RQ10
         end
         OCS_GOT_KEY1: begin
            if (wrCtrl) begin                                       // RQ13
               if (busReq.wdata == OCS_KEY_SECOND) lockNext = OCS_UNLOCKED;   // RQ10
               else if (busReq.wdata != OCS_KEY_FIRST) lockNext = OCS_LOCKED; // RQ12
            end
         end
         OCS_UNLOCKED: begin
            if (wrCtrl) begin
               ctrlNext = busReq.wdata;                             // RQ11
               // Reserved source code is not taken, keep the running clock
               if (busReq.wdata[OCS_SEL_HI:OCS_SEL_LO] == OCS_SRC_RESERVED)
                  ctrlNext[OCS_SEL_HI:OCS_SEL_LO] = ctrlReg[OCS_SEL_HI:OCS_SEL_LO]; // RQ16
               lockNext = OCS_LOCKED;                               // RQ11
            end else if (wrDiv) begin
               divNext  = busReq.wdata;                             // RQ17
               lockNext = OCS_LOCKED;                               // RQ17
            end
         end
         default: lockNext = OCS_LOCKED;
      endcase
   end

   // Reset values; flash low power comes on when the option bit is zero
   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         lockReg <= OCS_LOCKED;
         ctrlReg <= OCS_CTRL_RESET;                                 // RQ7
         divReg  <= OCS_DIV_RESET;
      end else if (lpResetReg && !lowPowerOptionN) begin
         lockReg <= lockNext;
         ctrlReg <= ctrlNext | (8'h01 << OCS_BIT_FLASH_SAVE);
         divReg  <= OCS_DIV_RESET_LP;
      end else begin
         lockReg <= lockNext;
         ctrlReg <= ctrlNext;
         divReg  <= divNext;
      end
   end

   // ---------------------------------------------------------------
   // Trim index, trim locations and reload from nonvolatile storage
   // ---------------------------------------------------------------
   always_comb begin
      indexNext   = indexReg;
      trimUpNext  = trimUpReg;
      trimLoNext  = trimLoReg;
      reloadNext  = stopRecovery;
      lpResetNext = 1'b0;
      if (busReq.wr && busReq.addr == OCS_ADDR_TRIM_INDEX) indexNext = busReq.wdata; // RQ1
      // Writes touch only the working copy, never the stored image
      if (wrTrim && indexReg == OCS_TRIM_UPPER) trimUpNext = busReq.wdata; // RQ2 RQ4
      if (wrTrim && indexReg == OCS_TRIM_LOWER) trimLoNext = busReq.wdata; // RQ2 RQ4
      // Reload beats a software write in the same cycle
      if (reloadReg) begin
         trimUpNext = nvTrim.upper;                                 // RQ3
         trimLoNext = nvTrim.lower;                                 // RQ3
      end
   end

   // Reload is held pending through reset, since reset takes constants only
   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         indexReg   <= OCS_INDEX_RESET;                             // RQ1
         trimUpReg  <= 8'h00;
         trimLoReg  <= 8'h00;
         reloadReg  <= 1'b1;
         lpResetReg <= 1'b1;
      end else begin
         indexReg   <= indexNext;
         trimUpReg  <= trimUpNext;
         trimLoReg  <= trimLoNext;
         reloadReg  <= reloadNext;
         lpResetReg <= lpResetNext;
      end
   end

   // ---------------------------------------------------------------
   // Read data and flash power down
   // ---------------------------------------------------------------
   always_comb begin
      rdNext = 8'h00;
      if (busReq.rd) begin
         unique case (busReq.addr)
            OCS_ADDR_TRIM_INDEX: rdNext = indexReg;
            OCS_ADDR_TRIM_VALUE: rdNext = trimRead(indexReg, trimUpReg, trimLoReg); // RQ2
            OCS_ADDR_OSC_CTRL:   rdNext = ctrlReg;
            OCS_ADDR_CLK_DIV:    rdNext = divReg;
            default:             rdNext = 8'h00;
         endcase
      end
      // Crystal speed is unknown to logic, so the strap vouches for it
      fpdNext = ctrlReg[OCS_BIT_FLASH_SAVE] && !flashReadActive && sysClkTick &&
                (ctrlReg[OCS_SEL_HI:OCS_SEL_LO] != OCS_SRC_CRYSTAL || xtalSync); // RQ15
   end

   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         rdReg    <= 8'h00;
         fpdReg   <= 1'b0;
         xtalMeta <= 1'b0;
         xtalSync <= 1'b0;
      end else begin
         rdReg    <= rdNext;
         fpdReg   <= fpdNext;
         xtalMeta <= xtalSlowPin;
         xtalSync <= xtalMeta;
      end
   end

   // ---------------------------------------------------------------
   // Divider and outputs
   // ---------------------------------------------------------------
   ocs_clk_divider #(.WIDTH(8)) uDivider (
      .mclk     (mclk),
      .sys_rst  (sys_rst),
      .divValue (divReg),
      .clkTick  (tick)
   );

   assign sysClkTick         = tick;                                // RQ14
   assign regRdData          = rdReg;
   assign oscCtrl            = ctrlReg;
   assign sysclkSourceSelect = ocs_src_t'(ctrlReg[OCS_SEL_HI:OCS_SEL_LO]); // RQ16
   assign freqTrim           = {trimUpReg[1:0], trimLoReg};         // RQ5 RQ6
   assign tempTrim           = trimUpReg[7:2];                      // RQ5
   assign flashPowerDown     = fpdReg;

   // ---------------------------------------------------------------
   // Checks
   // ---------------------------------------------------------------
   default clocking cb @(posedge mclk); endclocking
   default disable iff (sys_rst);

   chk_first_key: assert property ( // RQ10
      (lockReg == OCS_LOCKED && wrCtrl && busReq.wdata == OCS_KEY_FIRST) |=>
      lockReg == OCS_GOT_KEY1) else $error("first key not taken");
   chk_second_key: assert property ( // RQ10
      (lockReg == OCS_GOT_KEY1 && wrCtrl && busReq.wdata == OCS_KEY_SECOND) |=>
      lockReg == OCS_UNLOCKED) else $error("second key not taken");
   chk_relock_after_write: assert property ( // RQ11
      (lockReg == OCS_UNLOCKED && wrCtrl) |=> lockReg == OCS_LOCKED && !lpResetReg)
      else $error("control register did not relock");
   chk_locked_ctrl_stable: assert property ( // RQ12
      (lockReg != OCS_UNLOCKED && !lpResetReg) |=> ctrlReg == $past(ctrlReg))
      else $error("locked control register changed");
   chk_keys_survive_gap: assert property ( // RQ13
      (lockReg == OCS_GOT_KEY1 && !wrCtrl) |=> lockReg == OCS_GOT_KEY1)
      else $error("unlock lost on unrelated cycle");
   chk_div_relock: assert property ( // RQ17
      (lockReg == OCS_UNLOCKED && wrDiv && !wrCtrl) |=>
      divReg == $past(busReq.wdata) && lockReg == OCS_LOCKED)
      else $error("divide register write or relock failed");
   chk_trim_reload: assert property ( // RQ3
      reloadReg |=> trimUpReg == $past(nvTrim.upper) && trimLoReg == $past(nvTrim.lower))
      else $error("trim not reloaded from storage");
   chk_trim_write: assert property ( // RQ4
      (wrTrim && indexReg == OCS_TRIM_LOWER && !reloadReg) |=>
      freqTrim[7:0] == $past(busReq.wdata)) else $error("trim write not applied");
   chk_unimpl_read: assert property ( // RQ18
      (busReq.rd && busReq.addr == OCS_ADDR_TRIM_VALUE &&
       indexReg != OCS_TRIM_UPPER && indexReg != OCS_TRIM_LOWER) |=> regRdData == 8'h00)
      else $error("unimplemented trim index read nonzero");
   chk_reset_source: assert property ( // RQ7
      $past(sys_rst) |-> sysclkSourceSelect == OCS_SRC_PRECISION && indexReg == 8'h00)
      else $error("reset source or index wrong");
   chk_no_reserved_src: assert property ( // RQ16
      sysclkSourceSelect != OCS_SRC_RESERVED) else $error("reserved source selected");

   cov_unlock_write: cover property (
      lockReg == OCS_UNLOCKED && wrCtrl ##1 sysclkSourceSelect == OCS_SRC_WATCHDOG);
   cov_gap_unlock: cover property (
      lockReg == OCS_GOT_KEY1 && busReq.wr && !wrCtrl ##[1:4] lockReg == OCS_UNLOCKED);
   cov_stop_reload: cover property (stopRecovery ##2 freqTrim != 10'h000);

endmodule // ocs_osc_ctrl

// >>> logic/ocs_pkg.sv
// Constants, register map and carrier types for the oscillator select and trim block.
// Assumes an 8-bit register port with a 12-bit address, clocked by mclk.
//
// Summary of operation
// [RQ1] Trim index register, 8 bits read/write, indexes 00-1F, resets to zero.
// [RQ2] Trim value register reads and writes the trim location that the index selects.
// [RQ3] Trim locations 1 and 2 reload from nonvolatile storage after reset and stop recovery.
// [RQ4] Trim writes change oscillator adjustment at once, nonvolatile copy untouched.
// [RQ5] Location 1: bits 7:2 temperature trim, bits 1:0 frequency trim bits 9:8.
// [RQ6] Location 2 holds frequency trim bits 7:0.
// [RQ7] Internal precision oscillator is the clock source after reset.
// [RQ8] Software enables crystal, waits 50 ms, then selects it with another unlocked write.
// [RQ9] Software enables and selects the watchdog oscillator in one unlocked write.
// [RQ10] Control register unlocks only after E7 then 18 written to its address.
// [RQ11] Next write after unlock updates the register, then it relocks.
// [RQ12] Writes to the locked control register without correct unlock order change nothing.
// [RQ13] Other bus cycles between the two keys do not break the unlock.
// [RQ14] Selected oscillator passes a programmable divider to lower the system clock.
// [RQ15] Below 10 MHz with flash low power on, flash powers down while idle.
// [RQ16] Source field: 00 precision RC, 01 crystal, 11 watchdog, 10 reserved.
// [RQ17] Divide register uses the same key at control address, relocks after one write.
// [RQ18] Unimplemented trim indexes read zero and ignore writes.

package ocs_pkg;

   // ---------------------------------------------------------------
   // Register map
   // ---------------------------------------------------------------
   localparam logic [11:0] OCS_ADDR_TRIM_INDEX = 12'hff6;
   localparam logic [11:0] OCS_ADDR_TRIM_VALUE = 12'hff7;
   localparam logic [11:0] OCS_ADDR_OSC_CTRL   = 12'hf86;
   localparam logic [11:0] OCS_ADDR_CLK_DIV    = 12'hf87;

   // ---------------------------------------------------------------
   // Unlock keys and trim locations
   // ---------------------------------------------------------------
   localparam logic [7:0] OCS_KEY_FIRST   = 8'he7;
   localparam logic [7:0] OCS_KEY_SECOND  = 8'h18;
   localparam logic [7:0] OCS_TRIM_UPPER  = 8'h01;
   localparam logic [7:0] OCS_TRIM_LOWER  = 8'h02;
   localparam logic [7:0] OCS_TRIM_IDXMAX = 8'h1f;

   // ---------------------------------------------------------------
   // Control register fields and reset values
   // ---------------------------------------------------------------
   localparam int OCS_BIT_FLASH_SAVE = 2;
   localparam int OCS_SEL_HI         = 1;
   localparam int OCS_SEL_LO         = 0;
   localparam logic [7:0] OCS_CTRL_RESET    = 8'ha0;
   localparam logic [7:0] OCS_DIV_RESET     = 8'h00;
   localparam logic [7:0] OCS_DIV_RESET_LP  = 8'h08;
   localparam logic [7:0] OCS_INDEX_RESET   = 8'h00;

   // Clock source codes
   typedef enum logic [1:0] {
      OCS_SRC_PRECISION = 2'b00,
      OCS_SRC_CRYSTAL   = 2'b01,
      OCS_SRC_RESERVED  = 2'b10,
      OCS_SRC_WATCHDOG  = 2'b11
   } ocs_src_t;

   // Unlock tracker states
   typedef enum logic [1:0] {
      OCS_LOCKED   = 2'b00,
      OCS_GOT_KEY1 = 2'b01,
      OCS_UNLOCKED = 2'b10
   } ocs_lock_t;

   // Register port request
   typedef struct packed {
      logic [11:0] addr;
      logic        wr;
      logic        rd;
      logic [7:0]  wdata;
   } ocs_bus_req_t;

   // Nonvolatile trim image
   typedef struct packed {
      logic [7:0] upper;
      logic [7:0] lower;
   } ocs_nv_trim_t;

endpackage : ocs_pkg
